// ===== hw/ffmd_core.sv
// Free-fall/motion detector: configuration, debounce and source flags
// Functional notes
// - Latch on: axis flags freeze once event-active sets; source read clears them.
// - Latch off: source flags follow the live detection every sample.
// - Select 0: event-active is AND of low-g on all enabled axes.
// - Select 1: event-active is OR of high-g on enabled axes.
// - Config bits 5,4,3 enable Z,Y,X detection; 0 disables the axis.
// - While a latched event is held, new axis events cannot change source.
// - Source bit 7 is set once the selected axis combination has held for the debounce length.
// - Interrupt comes from event-active, gated by enable, steered by route bit.
// - Source bits 5,3,1 report Z,Y,X events: low-g in select 0, high-g in select 1.
// - Source bits 4,2,0 give Z,Y,X event sign, 1 meaning negative.
// - Axis event and sign read zero while that axis is disabled.
// - Source ignores writes; all bits, reserved bit 6 too, reset to zero.
// - Condition false: counter clears if mode bit 1, else decrements to zero.
// - Common 7-bit threshold at fixed 63 mg steps, whatever the range.
// - Per-axis select 1: separate 13-bit thresholds scaled like the data.
`timescale 1ns/1ps
module ffmd_core #(
   parameter int DBNC_W = 8
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Host register port
   input wire ffmd_pkg::ffmd_req_t req_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   // Sample stream
   input wire logic sample_stb_i,
   input wire ffmd_pkg::ffmd_sample_t sample_i,
   input wire logic [1:0] full_scale_i,
   // Debounce length and interrupt control bits
   input wire logic [DBNC_W-1:0] dbnc_count_i,
   input wire logic int_enable_i,
   input wire logic int_route_i,
   // Interrupt pins
   output logic int1_o,
   output logic int2_o
);
   localparam int A = ffmd_pkg::AXES;

   if (DBNC_W < 1 || DBNC_W > 16) begin : g_bad_dbnc_w
      $error("DBNC_W out of range");
   end

   logic [7:0] cfg_r;
   logic [7:0] src_r;
   logic [7:0] src_nxt;
   logic [7:0] ths_r;
   logic [7:0] ths_msb_r [A];
   logic [7:0] ths_lsb_r [A];
   logic [DBNC_W-1:0] dbnc_r;
   logic [DBNC_W-1:0] dbnc_nxt;
   logic [7:0] rdata_r;
   logic rvalid_r;
   logic int1_r;
   logic int2_r;

   // Decode
   wire wr_cfg = req_i.wr && req_i.addr == ffmd_pkg::CFG_ADDR;
   wire wr_ths = req_i.wr && req_i.addr == ffmd_pkg::THS_ADDR;
   wire rd_src = req_i.rd && req_i.addr == ffmd_pkg::SRC_ADDR;
   wire [ffmd_pkg::ADDR_W-1:0] axis_off = req_i.addr - ffmd_pkg::THS_AXIS_BASE;
   wire axis_hit = req_i.addr >= ffmd_pkg::THS_AXIS_BASE && axis_off < 8'(2 * A);
   wire wr_axis = req_i.wr && axis_hit;
   // Index 3 is never reached: axis_hit bounds the offset
   wire [1:0] axis_idx = axis_off[2:1];

   wire latch_en = cfg_r[ffmd_pkg::CFG_LATCH_BIT];
   wire or_mode = cfg_r[ffmd_pkg::CFG_OR_BIT];
   wire [A-1:0] axis_en = cfg_r[ffmd_pkg::CFG_EN_LSB +: A];
   wire clr_mode = ths_r[ffmd_pkg::THS_CLRMODE_BIT];
   // Per-axis select bit lives in the X high byte
   wire xyz_en = ths_msb_r[0][ffmd_pkg::THS_XYZ_EN_BIT];
   // Range code 3 is undefined and simply shifts by three
   wire [ffmd_pkg::CMP_W-1:0] common_thr =
      ffmd_pkg::CMP_W'((32'(ths_r[ffmd_pkg::COMMON_THS_W-1:0]) * ffmd_pkg::COMMON_STEP_COUNTS)
                       >> full_scale_i);

   logic [ffmd_pkg::DATA_W-1:0] acc [A];
   logic [A-1:0] hi_g;
   logic [A-1:0] lo_g;
   logic [A-1:0] neg;
   assign acc[0] = sample_i.x;
   assign acc[1] = sample_i.y;
   assign acc[2] = sample_i.z;

   genvar g;
   generate
      for (g = 0; g < A; g++) begin : g_axis
         // Guard bit so the most negative sample negates without overflow
         wire [ffmd_pkg::CMP_W-1:0] mag = acc[g][ffmd_pkg::DATA_W-1] ?
            ffmd_pkg::CMP_W'(-$signed({acc[g][ffmd_pkg::DATA_W-1], acc[g]})) :
            ffmd_pkg::CMP_W'(acc[g]);
         wire [ffmd_pkg::AXIS_THS_W-1:0] own_thr =
            {ths_msb_r[g][ffmd_pkg::COMMON_THS_W-1:0], ths_lsb_r[g][ffmd_pkg::AXIS_LSB_W-1:0]};
         wire [ffmd_pkg::CMP_W-1:0] thr = xyz_en ? ffmd_pkg::CMP_W'(own_thr) : common_thr;
         assign hi_g[g] = mag > thr;
         assign lo_g[g] = mag < thr;
         assign neg[g] = acc[g][ffmd_pkg::DATA_W-1];
      end
   endgenerate

   // Combined condition; an all-disabled AND never fires
   wire [A-1:0] axis_hit_v = (or_mode ? hi_g : lo_g) & axis_en;
   wire cond_or = |axis_hit_v;
   wire cond_and = (&(lo_g | ~axis_en)) && (|axis_en);
   wire cond = or_mode ? cond_or : cond_and;

   // Debounce: event fires when the counter reaches the programmed length
   // Length zero fires on the first true sample
   always_comb begin
      dbnc_nxt = dbnc_r;
      if (cond) begin
         if (dbnc_r != dbnc_count_i) dbnc_nxt = dbnc_r + 1'b1;
      end else if (clr_mode) begin
         dbnc_nxt = '0;
      end else if (dbnc_r != '0) begin
         dbnc_nxt = dbnc_r - 1'b1;
      end
   end
   wire event_live = cond && dbnc_nxt == dbnc_count_i;

   logic [7:0] live_src;
   always_comb begin
      live_src = ffmd_pkg::SRC_RST;
      live_src[ffmd_pkg::SRC_ACTIVE_BIT] = event_live;
      for (int i = 0; i < A; i++) begin
         live_src[2*i+1] = axis_hit_v[i];
         live_src[2*i] = axis_hit_v[i] & neg[i];
      end
   end

   // Live mode never blocks a sample
   wire held = latch_en && src_r[ffmd_pkg::SRC_ACTIVE_BIT];
   wire sample_take = sample_stb_i && !held;
   // Set wins over clear-on-read: a sample landing on the read is kept unless a latched event is held
   always_comb begin
      src_nxt = src_r;
      if (rd_src) src_nxt = ffmd_pkg::SRC_RST;
      if (sample_take) src_nxt = live_src;
   end

   // Disabled axes read as zero
   logic [7:0] src_view;
   always_comb begin
      src_view = src_r;
      for (int i = 0; i < A; i++) begin
         if (!axis_en[i]) begin
            src_view[2*i+1] = 1'b0;
            src_view[2*i] = 1'b0;
         end
      end
   end

   // Unmapped addresses read as zero
   wire [7:0] rd_mux =
      req_i.addr == ffmd_pkg::CFG_ADDR ? cfg_r :
      req_i.addr == ffmd_pkg::SRC_ADDR ? src_view :
      req_i.addr == ffmd_pkg::THS_ADDR ? ths_r :
      axis_hit ? (axis_off[0] ? ths_lsb_r[axis_idx] : ths_msb_r[axis_idx]) :
      8'h00;

   wire event_active_flag = src_r[ffmd_pkg::SRC_ACTIVE_BIT];
   wire int_fire = event_active_flag && int_enable_i;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         cfg_r <= ffmd_pkg::CFG_RST;
         ths_r <= ffmd_pkg::THS_RST;
         for (int i = 0; i < A; i++) begin
            ths_msb_r[i] <= ffmd_pkg::THS_AXIS_RST;
            ths_lsb_r[i] <= ffmd_pkg::THS_AXIS_RST;
         end
      end else begin
         if (wr_cfg) cfg_r <= req_i.wdata;
         if (wr_ths) ths_r <= req_i.wdata;
         if (wr_axis) begin
            if (axis_off[0]) ths_lsb_r[axis_idx] <= req_i.wdata;
            else ths_msb_r[axis_idx] <= req_i.wdata;
         end
      end
   end

   // Source has no write path at all
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         src_r <= ffmd_pkg::SRC_RST;
         dbnc_r <= '0;
      end else begin
         src_r <= src_nxt;
         if (sample_stb_i) dbnc_r <= dbnc_nxt;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= req_i.rd;
         if (req_i.rd) rdata_r <= rd_mux;
      end
   end

   // Registered pins: one cycle behind the event-active bit
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         int1_r <= 1'b0;
         int2_r <= 1'b0;
      end else begin
         int1_r <= int_fire && int_route_i;
         int2_r <= int_fire && !int_route_i;
      end
   end

   assign rdata_o = rdata_r;
   assign rvalid_o = rvalid_r;
   assign int1_o = int1_r;
   assign int2_o = int2_r;

   // Checks
   latch_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      held && !rd_src |=> src_r == $past(src_r))
      else $error("latched source changed without a read");
   read_clear_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      rd_src && !(sample_stb_i && !held) |=> src_r == 8'h00)
      else $error("source not cleared by read");
   live_follow_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      sample_stb_i && !latch_en |=> src_r == $past(live_src))
      else $error("source not following live result");
   and_mode_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !or_mode && cond |-> (axis_en != 3'b000) && ((lo_g & axis_en) == axis_en))
      else $error("free-fall condition without all axes low");
   or_mode_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      or_mode |-> cond == |(hi_g & axis_en))
      else $error("motion condition mismatch");
   between_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !sample_stb_i |=> dbnc_r == $past(dbnc_r))
      else $error("debounce moved between samples");
   active_set_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      sample_stb_i && !held && event_live |=> event_active_flag ##1 (int1_o || int2_o || !$past(int_enable_i)))
      else $error("event-active or interrupt missing");
   irq_route_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      int1_o |-> $past(event_active_flag) && $past(int_route_i) && !int2_o)
      else $error("interrupt on wrong pin");
   clr_mode_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      sample_stb_i && !cond && clr_mode |=> dbnc_r == '0)
      else $error("debounce not cleared");
   dec_mode_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      sample_stb_i && !cond && !clr_mode && dbnc_r != '0 |=> dbnc_r == $past(dbnc_r) - 1'b1)
      else $error("debounce not decremented");
   mask_view_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !axis_en[0] |-> src_view[1:0] == 2'b00)
      else $error("disabled axis visible");
   reserved_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      ##1 src_r[6] == 1'b0)
      else $error("reserved source bit set");

   // Source flag checks
   hold_block_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      held && sample_stb_i && !rd_src |=> $stable(src_r))
      else $error("held source changed by a sample");
   ea_live_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      sample_take |=> event_active_flag == $past(event_live))
      else $error("event-active does not match the combination");
   hi_flag_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      sample_take && or_mode |=> src_r[1] == $past(hi_g[0] && axis_en[0]))
      else $error("X high flag mismatch");
   sign_flag_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      sample_take |=> src_r[4] == $past(axis_hit_v[2] && acc[2][ffmd_pkg::DATA_W-1]))
      else $error("Z sign flag mismatch");
   en_mask_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      sample_take && !axis_en[2] |=> src_r[5:4] == 2'h0)
      else $error("disabled Z axis raised a flag");
   mask_all_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      (src_view[5:0] & {{2{axis_en[2]}}, {2{axis_en[1]}}, {2{axis_en[0]}}}) == src_view[5:0])
      else $error("disabled axis flag readable");
   src_nowr_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      req_i.wr && req_i.addr == ffmd_pkg::SRC_ADDR && !req_i.rd && !sample_stb_i |=> $stable(src_r))
      else $error("source changed by a write");
   read_view_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      rd_src |=> rdata_o == $past(src_view))
      else $error("source read data mismatch");

   // Mode checks
   lo_flag_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      sample_take && !or_mode |=> src_r[3] == $past(lo_g[1] && axis_en[1]))
      else $error("Y low flag mismatch");
   and_none_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !or_mode && axis_en == 3'h0 |-> !cond)
      else $error("free-fall fired with no axis enabled");

   // Interrupt pin checks
   int2_route_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      int2_o |-> $past(event_active_flag) && !$past(int_route_i) && !int1_o)
      else $error("interrupt on wrong pin");
   int_off_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !int_enable_i |=> !int1_o && !int2_o)
      else $error("interrupt while disabled");
endmodule : ffmd_core

// ===== hw/ffmd_pkg.sv
// Package: register map, field layout and types of the free-fall/motion detector
package ffmd_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 14;
   localparam int AXES = 3;
   // Register offsets
   localparam logic [7:0] CFG_ADDR = 8'h15;
   localparam logic [7:0] SRC_ADDR = 8'h16;
   localparam logic [7:0] THS_ADDR = 8'h17;
   localparam logic [7:0] THS_AXIS_BASE = 8'h73;
   // Reset values
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] SRC_RST = 8'h00;
   localparam logic [7:0] THS_RST = 8'h00;
   localparam logic [7:0] THS_AXIS_RST = 8'h00;
   // Configuration fields
   localparam int CFG_LATCH_BIT = 7;
   localparam int CFG_OR_BIT = 6;
   localparam int CFG_EN_LSB = 3;
   // Source fields: axis n event at 2n+1, sign at 2n
   localparam int SRC_ACTIVE_BIT = 7;
   // Threshold fields
   localparam int THS_CLRMODE_BIT = 7;
   localparam int THS_XYZ_EN_BIT = 7;
   localparam int COMMON_THS_W = 7;
   localparam int AXIS_THS_W = 13;
   localparam int AXIS_LSB_W = 6;
   // Common threshold step (63 mg) in data counts at the finest range
   localparam int COMMON_STEP_COUNTS = 258;
   localparam int CMP_W = 16;

   typedef struct packed {
      logic signed [DATA_W-1:0] z;
      logic signed [DATA_W-1:0] y;
      logic signed [DATA_W-1:0] x;
   } ffmd_sample_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } ffmd_req_t;
endpackage : ffmd_pkg

// ===== test/tb_ffmd_core.sv
// Self-checking testbench of the free-fall/motion detector core
`timescale 1ns/1ps
module tb_ffmd_core;
   typedef struct packed {
      logic [7:0] cfg;
      logic [1:0] fs;
      logic [13:0] x;
      logic [13:0] y;
      logic [13:0] z;
      logic [7:0] src;
   } ffmd_row_t;
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   ffmd_pkg::ffmd_req_t req_i = '0;
   ffmd_pkg::ffmd_sample_t sample_i = '0;
   logic sample_stb_i = 1'b0;
   logic [1:0] full_scale_i = 2'h0;
   logic [7:0] dbnc_count_i = 8'h00;
   logic int_enable_i = 1'b1;
   logic int_route_i = 1'b0;
   logic [7:0] rdata_o;
   logic rvalid_o;
   logic int1_o;
   logic int2_o;
   int mismatches = 0;
   int cmp_count = 0;
   // Common threshold 1 gives 258 counts at the finest range
   ffmd_row_t rows [11] = '{
      '{8'h08, 2'h0, 14'h0000, 14'h0000, 14'h0000, 8'h82},
      '{8'h48, 2'h0, 14'h3C18, 14'h0000, 14'h0000, 8'h83},
      '{8'h48, 2'h0, 14'h0102, 14'h0000, 14'h0000, 8'h00},
      '{8'h48, 2'h0, 14'h0103, 14'h0000, 14'h0000, 8'h82},
      '{8'h48, 2'h1, 14'h0082, 14'h0000, 14'h0000, 8'h82},
      '{8'h48, 2'h2, 14'h0041, 14'h0000, 14'h0000, 8'h82},
      '{8'h48, 2'h2, 14'h0040, 14'h0000, 14'h0000, 8'h00},
      '{8'h70, 2'h0, 14'h3C18, 14'h01F4, 14'h0000, 8'h88},
      '{8'h38, 2'h0, 14'h0000, 14'h0000, 14'h03E8, 8'h0A},
      '{8'h38, 2'h0, 14'h3FFB, 14'h0005, 14'h3FFB, 8'hBB},
      '{8'h00, 2'h0, 14'h0000, 14'h0000, 14'h0000, 8'h00}
   };

   always #2 clk_sys_i = ~clk_sys_i;

   ffmd_core #(.DBNC_W(8)) u_ffmd_core (
      .clk_sys_i(clk_sys_i), .srst_i(srst_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .sample_stb_i(sample_stb_i), .sample_i(sample_i), .full_scale_i(full_scale_i),
      .dbnc_count_i(dbnc_count_i), .int_enable_i(int_enable_i), .int_route_i(int_route_i),
      .int1_o(int1_o), .int2_o(int2_o)
   );

   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp8

   task automatic cmp_int(input logic [1:0] exp);
      cmp8("int pins", {6'h00, exp}, {6'h00, int1_o, int2_o});
   endtask : cmp_int

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i) #1;
      req_i = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk_sys_i) #1;
      req_i.wr = 1'b0;
   endtask : wr

   // Answer is fixed one cycle after the request
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i) #1;
      req_i = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clk_sys_i) #1;
      req_i.rd = 1'b0;
      cmp8("rvalid", 8'h01, {7'h00, rvalid_o});
      cmp8($sformatf("reg %h", a), exp, rdata_o);
   endtask : rd

   task automatic smp(input logic [13:0] x);
      @(posedge clk_sys_i) #1;
      sample_i = {14'h0000, 14'h0000, x};
      sample_stb_i = 1'b1;
      @(posedge clk_sys_i) #1;
      sample_stb_i = 1'b0;
   endtask : smp

   // Hang guard
   initial begin
      #100000;
      mismatches++;
      $display("mismatch run time expected end seen timeout");
      end_sim();
   end

   initial begin
      repeat (3) @(posedge clk_sys_i);
      #1 srst_i = 1'b0;
      wr(ffmd_pkg::THS_ADDR, 8'h01);
      foreach (rows[i]) begin
         wr(ffmd_pkg::CFG_ADDR, rows[i].cfg);
         full_scale_i = rows[i].fs;
         int_route_i = i[0];
         @(posedge clk_sys_i) #1;
         sample_i = {rows[i].z, rows[i].y, rows[i].x};
         sample_stb_i = 1'b1;
         @(posedge clk_sys_i) #1;
         sample_stb_i = 1'b0;
         @(posedge clk_sys_i) #1;
         cmp_int({rows[i].src[7] & i[0], rows[i].src[7] & ~i[0]});
         rd(ffmd_pkg::SRC_ADDR, rows[i].src);
      end
      full_scale_i = 2'h0;
      $display("test rows done");
      // Reset in mid-run with a live event pending
      wr(ffmd_pkg::CFG_ADDR, 8'h48);
      smp(14'h3C18);
      srst_i = 1'b1;
      repeat (3) @(posedge clk_sys_i);
      #1 srst_i = 1'b0;
      cmp_int(2'h0);
      rd(ffmd_pkg::CFG_ADDR, 8'h00);
      rd(ffmd_pkg::SRC_ADDR, 8'h00);
      rd(ffmd_pkg::THS_ADDR, 8'h00);
      wr(ffmd_pkg::SRC_ADDR, 8'hFF);
      rd(ffmd_pkg::SRC_ADDR, 8'h00);
      rd(8'h20, 8'h00);
      $display("test reset done");
      // Latched event blocks later samples until read
      wr(ffmd_pkg::THS_ADDR, 8'h01);
      wr(ffmd_pkg::CFG_ADDR, 8'hC8);
      int_route_i = 1'b1;
      smp(14'h3C18);
      smp(14'h03E8);
      smp(14'h0000);
      cmp_int(2'b10);
      int_enable_i = 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1 cmp_int(2'b00);
      int_enable_i = 1'b1;
      rd(ffmd_pkg::SRC_ADDR, 8'h83);
      rd(ffmd_pkg::SRC_ADDR, 8'h00);
      smp(14'h03E8);
      rd(ffmd_pkg::SRC_ADDR, 8'h82);
      // Live mode keeps no past event
      wr(ffmd_pkg::CFG_ADDR, 8'h48);
      smp(14'h03E8);
      smp(14'h0000);
      rd(ffmd_pkg::SRC_ADDR, 8'h00);
      $display("test latch done");
      // Per-axis X threshold of 100 counts overrides the common one
      wr(ffmd_pkg::THS_AXIS_BASE, 8'h81);
      wr(ffmd_pkg::THS_AXIS_BASE + 8'h01, 8'h24);
      rd(ffmd_pkg::THS_AXIS_BASE, 8'h81);
      rd(ffmd_pkg::THS_AXIS_BASE + 8'h01, 8'h24);
      smp(14'h0065);
      rd(ffmd_pkg::SRC_ADDR, 8'h82);
      smp(14'h0064);
      rd(ffmd_pkg::SRC_ADDR, 8'h00);
      wr(ffmd_pkg::THS_AXIS_BASE, 8'h00);
      $display("test axis threshold done");
      // High, high, low, high: only decrement mode reaches a count of 2 again
      dbnc_count_i = 8'h02;
      for (int m = 1; m >= 0; m--) begin
         wr(ffmd_pkg::THS_ADDR, {m[0], 7'h01});
         repeat (3) smp(14'h0000);
         smp(14'h03E8);
         smp(14'h03E8);
         smp(14'h0000);
         smp(14'h03E8);
         rd(ffmd_pkg::SRC_ADDR, m[0] ? 8'h02 : 8'h82);
      end
      $display("test debounce done");
      end_sim();
   end
endmodule : tb_ffmd_core
